// [hdl/evg_params.svh]
`ifndef EVG_PARAMS_SVH
`define EVG_PARAMS_SVH
// Register byte offsets
`define EVG_CTRL_OFS     12'h000
`define EVG_BTN_T1_OFS   12'h004
`define EVG_BTN_T2_OFS   12'h008
`define EVG_POS_CFG_OFS  12'h00c
`define EVG_OCC_CFG_OFS  12'h010
`define EVG_OCC_DEAD_OFS 12'h014
`define EVG_STATUS_OFS   12'h018
`define EVG_MASK_OFS     12'h01c
`define EVG_INFO_OFS     12'h020
// Field positions (low bit of each field)
`define EVG_SHORT_LSB    0
`define EVG_DOUBLE_LSB   16
`define EVG_REPEAT_LSB   0
`define EVG_STUCK_LSB    16
`define EVG_PREP_LSB     0
`define EVG_PDEAD_LSB    16
`define EVG_HOLD_LSB     0
`define EVG_OREP_LSB     16
`define EVG_ODEAD_LSB    0
// Reset values
`define EVG_CTRL_RST     14'h3fff
`define EVG_SHORT_RST    13'h01f4
`define EVG_DOUBLE_RST   12'h0258
`define EVG_REPEAT_RST   11'h0c8
`define EVG_STUCK_RST    8'h0a
`define EVG_HOLD_RST     12'h001
// Timing
`define EVG_CLK_NS       100
`define EVG_MS_NS        1000000
`define EVG_MS_CYCLES    (`EVG_MS_NS / `EVG_CLK_NS)
`define EVG_SEC_MS       1000
`endif

// [hdl/evg_pkg.sv]
package evg_pkg;
   typedef enum logic [5:0] {
      BT_IDLE  = 6'h01,
      BT_DOWN1 = 6'h02,
      BT_WAIT2 = 6'h04,
      BT_DOWN2 = 6'h08,
      BT_LONG  = 6'h10,
      BT_STUCK = 6'h20
   } evg_bst_e;

   typedef enum logic [3:0] {
      EV_PRESS = 4'h0, EV_RELEASE = 4'h1, EV_SHORT = 4'h2, EV_DOUBLE = 4'h3,
      EV_LSTART = 4'h4, EV_LREP = 4'h5, EV_LSTOP = 4'h6, EV_STUCK = 4'h7,
      EV_FREE = 4'h8, EV_POS = 4'h9, EV_OCC = 4'ha, EV_VAC = 4'hb,
      EV_MOVE = 4'hc, EV_NOMOVE = 4'hd
   } evg_ev_e;

   typedef struct packed {
      logic       valid;
      evg_ev_e    code;
      logic [7:0] data;
   } evg_event_s;

   typedef struct packed {
      logic [15:0] ms_div;
      logic        ms_tick;
      logic [9:0]  ms_cnt;
      logic        sec_tick;
      logic        btn_s1, btn_s2, btn_q;
      logic [7:0]  pos_s1, pos_s2, pos_last;
      logic        occ_s1, occ_s2, mot_s1, mot_s2, mot_q;
      evg_bst_e    bst;
      logic [13:0] btn_ms;
      logic [7:0]  btn_s;
      logic [10:0] rep_ms;
      logic [7:0]  pos_rep_s;
      logic        pos_arm;
      logic [13:0] pos_dead;
      logic        occ_state;
      logic [11:0] occ_hold_s;
      logic [7:0]  occ_rep_s;
      logic        occ_arm;
      logic [13:0] occ_dead;
      logic [3:0]  occ_wait;
      logic [13:0] pend;
      logic [13:0] ctrl;
      logic [12:0] short_ms;
      logic [11:0] double_ms;
      logic [10:0] repeat_ms;
      logic [7:0]  stuck_s;
      logic [7:0]  prep_s;
      logic [13:0] pdead_ms;
      logic [11:0] hold_s;
      logic [7:0]  orep_s;
      logic [13:0] odead_ms;
      logic [13:0] status;
      logic [13:0] mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      evg_event_s  evt;
   } evg_state_s;
endpackage

// [hdl/evg_event_gen.sv]
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "evg_params.svh"

// Behaviour
// R1: Press then release inside short window gives short event when enabled.
// R2: Two press-release cycles inside double window give double event when enabled.
// R3: While held in long press, emit repeat events every repeat interval.
// R4: Hold beyond stuck time stops all further long-press events for that hold.
// R5: Every button event type has its own enable; disabled types never emitted. The free event has none and is gated by the stuck enable ctrl[7].
// R6: Position is reported periodically at the report interval when enabled.
// R7: Position events wait the position dead time before going out.
// R8: Occupancy state held at least the hold time before changing.
// R9: With repeat enabled, occupancy event re-sent each report interval.
// R10: Occupancy events wait the occupancy dead time before going out.
// R11: Occupied, vacant, movement, no-movement each gated by own enable.
// R12: All timing from a millisecond tick; counters clear on reset and new press/change.
module evg_event_gen
   import evg_pkg::*;
#(
   parameter int MS_CYCLES = `EVG_MS_CYCLES
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        button_in,
   input  wire logic [7:0]  position_in,
   input  wire logic        occupied_in,
   input  wire logic        motion_in,
   output evg_event_s       evt,
   output logic             irq
);

   evg_state_s r;
   evg_state_s n;

   logic [13:0] raw;
   logic [13:0] en_mask;
   logic [13:0] avail;
   logic [13:0] wclr;
   logic [13:0] sent;
   logic [15:0] dn;
   logic        rise;
   logic        fall;
   logic        pos_trig;
   logic        occ_trig;
   logic [3:0]  occ_kind;
   logic        wr;
   logic        rd_setup;

   function automatic logic [15:0] dead_step(input logic trig, input logic armed, input logic [13:0] cnt,
                                             input logic [13:0] cfg, input logic tick);
      logic [15:0] res;
      res = {1'b0, armed, cnt};
      // A new event restarts the wait, so all events that came during one wait go out together when it ends
      if (trig)
         res = (cfg == 14'h0000) ? 16'h8000 : {2'b01, cfg};
      else if (armed && tick)
         res = (cnt <= 14'h0001) ? 16'h8000 : {2'b01, cnt - 14'h0001};
      return res;
   endfunction
   function automatic logic [13:0] inc14(input logic [13:0] v);
      return (v == 14'h3fff) ? v : v + 14'h0001;
   endfunction
   function automatic logic [3:0] first_set(input logic [13:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 13; i >= 0; i--)
      begin
         if (v[i])
            idx = 4'(i);
      end
      return idx;
   endfunction

   always_comb
   begin
      n        = r;
      raw      = 14'h0000;
      pos_trig = 1'b0;
      occ_trig = 1'b0;
      occ_kind = 4'h0;
      wclr     = 14'h0000;
      sent     = 14'h0000;
      dn       = 16'h0000;

      // Millisecond and second ticks
      n.ms_tick  = 1'b0;
      n.sec_tick = 1'b0;
      if (r.ms_div >= 16'(MS_CYCLES - 1))
      begin
         n.ms_div  = 16'h0000;
         n.ms_tick = 1'b1;
      end
      else
         n.ms_div = r.ms_div + 16'h0001;
      if (r.ms_tick)
      begin
         if (r.ms_cnt >= 10'(`EVG_SEC_MS - 1))
         begin
            n.ms_cnt   = 10'h000;
            n.sec_tick = 1'b1;
         end
         else
            n.ms_cnt = r.ms_cnt + 10'h001;
      end

      // Pin synchronisers
      n.btn_s1 = button_in;
      n.btn_s2 = r.btn_s1;
      n.pos_s1 = position_in;
      n.pos_s2 = r.pos_s1;
      n.occ_s1 = occupied_in;
      n.occ_s2 = r.occ_s1;
      n.mot_s1 = motion_in;
      n.mot_s2 = r.mot_s1;

      // Button
      n.btn_q = r.btn_s2;
      rise    = r.btn_s2 & ~r.btn_q;
      fall    = ~r.btn_s2 & r.btn_q;
      if (rise)
         raw[EV_PRESS] = 1'b1;                                                  // see R5
      if (fall)
         raw[EV_RELEASE] = 1'b1;                                                // see R5
      if (r.ms_tick)
         n.btn_ms = inc14(r.btn_ms);                                            // see R12
      if (r.sec_tick && r.btn_s != 8'hff)
         n.btn_s = r.btn_s + 8'h01;
      unique case (r.bst)
         BT_IDLE:
         begin
            if (rise)
            begin
               n.bst    = BT_DOWN1;
               n.btn_ms = 14'h0000;                                             // see R12
               n.btn_s  = 8'h00;
            end
         end
         BT_DOWN1:
         begin
            if (fall)
            begin
               // Short press is held back while a second press may still come
               if (r.ctrl[EV_DOUBLE])
                  n.bst = BT_WAIT2;
               else
               begin
                  raw[EV_SHORT] = 1'b1;                                         // see R1
                  n.bst         = BT_IDLE;
               end
            end
            else if (r.btn_ms >= 14'(r.short_ms))
            begin
               raw[EV_LSTART] = 1'b1;
               n.rep_ms       = 11'h000;
               n.bst          = BT_LONG;
            end
         end
         BT_WAIT2:
         begin
            if (rise)
               n.bst = BT_DOWN2;
            else if (r.btn_ms >= 14'(r.double_ms))
            begin
               raw[EV_SHORT] = 1'b1;                                            // see R1
               n.bst         = BT_IDLE;
            end
         end
         BT_DOWN2:
         begin
            if (fall)
            begin
               if (r.btn_ms < 14'(r.double_ms))
                  raw[EV_DOUBLE] = 1'b1;                                        // see R2
               n.bst = BT_IDLE;
            end
         end
         BT_LONG:
         begin
            if (r.ms_tick)
               n.rep_ms = r.rep_ms + 11'h001;
            if (fall)
            begin
               raw[EV_LSTOP] = 1'b1;
               n.bst         = BT_IDLE;
            end
            else if (r.ctrl[EV_STUCK] && r.btn_s >= r.stuck_s)
            begin
               raw[EV_STUCK] = 1'b1;                                            // see R4
               n.bst         = BT_STUCK;
            end
            else if (r.ms_tick && r.rep_ms + 11'h001 >= r.repeat_ms)
            begin
               raw[EV_LREP] = 1'b1;                                             // see R3
               n.rep_ms     = 11'h000;
            end
         end
         BT_STUCK:
         begin
            // No repeat and no stop while stuck; release reports free instead
            if (fall)
            begin
               raw[EV_FREE] = 1'b1;                                             // see R4
               n.bst        = BT_IDLE;
            end
         end
         default:
            n.bst = BT_IDLE;
      endcase

      // Position sensor
      n.pos_last = r.pos_s2;
      if (r.sec_tick)
         n.pos_rep_s = r.pos_rep_s + 8'h01;
      if (r.pos_s2 != r.pos_last)
         pos_trig = 1'b1;
      else if (r.sec_tick && r.prep_s != 8'h00 && r.pos_rep_s + 8'h01 >= r.prep_s)
         pos_trig = 1'b1;                                                       // see R6
      pos_trig = pos_trig & r.ctrl[8];
      if (pos_trig)
         n.pos_rep_s = 8'h00;                                                   // see R12
      dn = dead_step(pos_trig, r.pos_arm, r.pos_dead, r.pdead_ms, r.ms_tick);  // see R7
      raw[EV_POS] = dn[15];
      n.pos_arm   = dn[14];
      n.pos_dead  = dn[13:0];

      // Occupancy sensor
      if (r.sec_tick && r.occ_hold_s != 12'hfff)
         n.occ_hold_s = r.occ_hold_s + 12'h001;
      if (r.sec_tick)
         n.occ_rep_s = r.occ_rep_s + 8'h01;
      // Second tick free-runs, so one tick more than the hold count proves a full hold has passed
      if (r.occ_s2 != r.occ_state && r.occ_hold_s > r.hold_s)
      begin
         n.occ_state  = r.occ_s2;                                               // see R8
         n.occ_hold_s = 12'h000;                                                // see R12
         n.occ_rep_s  = 8'h00;
         occ_trig     = 1'b1;
         occ_kind     = r.occ_s2 ? 4'h1 : 4'h2;
      end
      else if (r.ctrl[11] && r.sec_tick && r.orep_s != 8'h00 && r.occ_rep_s + 8'h01 >= r.orep_s)
      begin
         n.occ_rep_s = 8'h00;
         occ_trig    = 1'b1;                                                    // see R9
         occ_kind    = r.occ_state ? 4'h1 : 4'h2;
      end
      n.mot_q = r.mot_s2;
      if (r.mot_s2 != r.mot_q)
      begin
         occ_trig = 1'b1;
         occ_kind = occ_kind | (r.mot_s2 ? 4'h4 : 4'h8);
      end
      n.occ_wait = r.occ_wait | occ_kind;
      dn = dead_step(occ_trig, r.occ_arm, r.occ_dead, r.odead_ms, r.ms_tick);  // see R10
      n.occ_arm  = dn[14];
      n.occ_dead = dn[13:0];
      if (dn[15])
      begin
         raw[13:10] = n.occ_wait;
         n.occ_wait = 4'h0;
      end

      // Enable gating and one event per cycle to the bus side
      en_mask = {r.ctrl[13:12], r.ctrl[10:9], r.ctrl[8], r.ctrl[7], r.ctrl[7:0]};
      avail   = r.pend | (raw & en_mask);                                       // see R5 R11
      n.evt   = '{valid: 1'b0, code: EV_PRESS, data: 8'h00};
      if (avail != 14'h0000)
      begin
         n.evt.valid = 1'b1;
         n.evt.code  = evg_ev_e'(first_set(avail));
         if (n.evt.code == EV_POS)
            n.evt.data = r.pos_s2;
         else if (n.evt.code >= EV_OCC)
            n.evt.data = {7'h00, r.occ_state};
         sent[first_set(avail)] = 1'b1;
      end
      n.pend = avail & ~sent;

      // APB slave: zero wait states, answer in the first access cycle
      rd_setup  = psel & ~penable;
      wr        = psel & penable & pwrite & r.pready;
      n.pready  = rd_setup;
      n.pslverr = 1'b0;
      n.prdata  = 32'h00000000;
      if (rd_setup)
      begin
         unique case (paddr)
            `EVG_CTRL_OFS:     n.prdata = {18'h00000, r.ctrl};
            `EVG_BTN_T1_OFS:   n.prdata = {4'h0, r.double_ms, 3'h0, r.short_ms};
            `EVG_BTN_T2_OFS:   n.prdata = {8'h00, r.stuck_s, 5'h00, r.repeat_ms};
            `EVG_POS_CFG_OFS:  n.prdata = {2'h0, r.pdead_ms, 8'h00, r.prep_s};
            `EVG_OCC_CFG_OFS:  n.prdata = {8'h00, r.orep_s, 4'h0, r.hold_s};
            `EVG_OCC_DEAD_OFS: n.prdata = {18'h00000, r.odead_ms};
            `EVG_STATUS_OFS:   n.prdata = {18'h00000, r.status};
            `EVG_MASK_OFS:     n.prdata = {18'h00000, r.mask};
            `EVG_INFO_OFS:     n.prdata = {10'h000, r.bst, 5'h00, r.mot_s2, r.occ_state, r.btn_s2, r.pos_s2};
            default:           n.pslverr = 1'b1;
         endcase
      end
      if (wr)
      begin
         unique case (paddr)
            `EVG_CTRL_OFS:     n.ctrl = pwdata[13:0];
            `EVG_BTN_T1_OFS:
            begin
               n.short_ms  = pwdata[`EVG_SHORT_LSB +: 13];
               n.double_ms = pwdata[`EVG_DOUBLE_LSB +: 12];
            end
            `EVG_BTN_T2_OFS:
            begin
               n.repeat_ms = pwdata[`EVG_REPEAT_LSB +: 11];
               n.stuck_s   = pwdata[`EVG_STUCK_LSB +: 8];
            end
            `EVG_POS_CFG_OFS:
            begin
               n.prep_s   = pwdata[`EVG_PREP_LSB +: 8];
               n.pdead_ms = pwdata[`EVG_PDEAD_LSB +: 14];
            end
            `EVG_OCC_CFG_OFS:
            begin
               n.hold_s = pwdata[`EVG_HOLD_LSB +: 12];
               n.orep_s = pwdata[`EVG_OREP_LSB +: 8];
            end
            `EVG_OCC_DEAD_OFS: n.odead_ms = pwdata[`EVG_ODEAD_LSB +: 14];
            `EVG_STATUS_OFS:   wclr = pwdata[13:0];
            `EVG_MASK_OFS:     n.mask = pwdata[13:0];
            default:           wclr = 14'h0000;
         endcase
      end
      // An event landing in the clearing cycle stays set
      n.status = (r.status & ~wclr) | sent;
      n.irq    = |(n.status & n.mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r           <= '0;
         r.bst       <= BT_IDLE;
         r.ctrl      <= `EVG_CTRL_RST;
         r.short_ms  <= `EVG_SHORT_RST;
         r.double_ms <= `EVG_DOUBLE_RST;
         r.repeat_ms <= `EVG_REPEAT_RST;
         r.stuck_s   <= `EVG_STUCK_RST;
         r.hold_s    <= `EVG_HOLD_RST;
      end
      else
         r <= n;
   end

   assign prdata  = r.prdata;
   assign pready  = r.pready;
   assign pslverr = r.pslverr;
   assign evt     = r.evt;
   assign irq     = r.irq;

endmodule
`default_nettype wire

// [dv/evg_event_gen_props.sv]
`timescale 1ns/10ps
`default_nettype none
module evg_event_gen_props
   import evg_pkg::*;
#(
   parameter int MS_CYCLES = 10000
)
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        button_in,
   input wire logic [7:0]  position_in,
   input wire logic        occupied_in,
   input wire logic        motion_in,
   input wire evg_event_s  evt,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer carries data");
   press_held_a: assert property (evt.valid && evt.code == EV_PRESS |-> $past(button_in, 3))
      else $error("press event without press");
   short_rel_a: assert property (evt.valid && evt.code == EV_SHORT |-> !$past(button_in, 3))
      else $error("short event while held");
   double_rel_a: assert property (evt.valid && evt.code == EV_DOUBLE |-> !$past(button_in, 3))
      else $error("double event while held");
   repeat_held_a: assert property (evt.valid && evt.code == EV_LREP |-> $past(button_in, 4))
      else $error("repeat event after release");
   btn_data_a: assert property (evt.valid && evt.code <= EV_FREE |-> evt.data == 8'h00)
      else $error("button event with data");
   pos_value_a: assert property (evt.valid && evt.code == EV_POS && $past(position_in, 3) == $past(position_in, 6)
      |-> evt.data == $past(position_in, 3))
      else $error("stale position value");
   occ_data_a: assert property (evt.valid && evt.code == EV_OCC |-> evt.data == 8'h01)
      else $error("occupied event with vacant state");
   vac_data_a: assert property (evt.valid && evt.code == EV_VAC |-> evt.data == 8'h00)
      else $error("vacant event with occupied state");
endmodule
bind evg_event_gen evg_event_gen_props #(.MS_CYCLES(MS_CYCLES)) props_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .button_in, .position_in, .occupied_in, .motion_in,
   .evt, .irq);
`default_nettype wire

// [dv/evg_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module evg_ctl_model
   import evg_pkg::*;
(
   input wire logic       pclk,
   input wire evg_event_s evt
);
   int         count = 0;
   logic [3:0] code_a [0:63];
   logic [7:0] data_a [0:63];
   // The bus side has no back-pressure, so every pulse is logged in arrival order
   always @(posedge pclk)
      if (evt.valid === 1'b1)
      begin
         code_a[count] <= evt.code;
         data_a[count] <= evt.data;
         count <= count + 1;
      end
endmodule
`default_nettype wire

// [dv/evg_event_gen_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED at %0t: %s", $time, m); end end
module evg_event_gen_tb
   import evg_pkg::*;
;
   localparam int MS = 10;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic        button_in, occupied_in, motion_in;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  position_in;
   evg_event_s  evt;
   int          bad_count, samples_checked, base;

   evg_event_gen #(.MS_CYCLES(MS)) evg_event_gen_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .button_in(button_in), .position_in(position_in), .occupied_in(occupied_in),
      .motion_in(motion_in), .evt(evt), .irq(irq));
   evg_ctl_model evg_ctl_model_i (.pclk(pclk), .evt(evt));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task final_report;
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      `CHK(pready, 1'b1, "no bus answer")
      if (pready !== 1'b1)
         final_report;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e, "read data")
      `CHK(err, ee, "slave error")
   endtask

   task ms(input int n);
      repeat (n * MS) @(posedge pclk);
   endtask

   task press(input int t);
      button_in <= 1'b1;
      ms(t);
      button_in <= 1'b0;
   endtask

   task quiet(input int t);
      ms(t);
      `CHK(evg_ctl_model_i.count, base, "early or extra event")
   endtask

   // Codes packed one nibble each, oldest first; data checked on the last event
   task expect_ev(input int n, input logic [15:0] c, input logic [7:0] d);
      int k;
      k = 0;
      while (evg_ctl_model_i.count < base + n && k < 25000)
      begin
         @(posedge pclk);
         k++;
      end
      `CHK(evg_ctl_model_i.count, base + n, "event count")
      if (k >= 25000)
         final_report;
      for (int i = 0; i < n; i++)
         `CHK(evg_ctl_model_i.code_a[base + i], c[4 * (n - 1 - i) +: 4], "event code")
      `CHK(evg_ctl_model_i.data_a[base + n - 1], d, "event data")
      base = base + n;
      $display("Test step done at %0t", $time);
   endtask

   task irqchk(input logic e);
      repeat (2) @(posedge pclk);
      `CHK(irq, e, "interrupt level")
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {button_in, position_in, occupied_in, motion_in} = '0;
      bad_count = 0;
      samples_checked = 0;
      base = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(12'h000, 32'h00003fff, 1'b0);
      rdchk(12'h004, 32'h025801f4, 1'b0);
      rdchk(12'h024, 32'h00000000, 1'b1);
      apb(1'b1, 12'h000, 32'h00003ff5);
      apb(1'b1, 12'h018, 32'h00003fff);
      press(50);
      expect_ev(2, 16'h0002, 8'h00);
      irqchk(1'b0);
      apb(1'b1, 12'h01c, 32'h00000004);
      irqchk(1'b1);
      rdchk(12'h018, 32'h00000005, 1'b0);
      apb(1'b1, 12'h018, 32'h00000004);
      irqchk(1'b0);
      press(800);
      expect_ev(4, 16'h0456, 8'h00);
      apb(1'b1, 12'h000, 32'h00003ffd);
      press(50);
      ms(50);
      press(50);
      expect_ev(3, 16'h0003, 8'h00);
      quiet(700);
      apb(1'b1, 12'h008, 32'h000107d0);
      press(1200);
      expect_ev(4, 16'h0478, 8'h00);
      apb(1'b1, 12'h00c, 32'h000a0000);
      position_in <= 8'h5a;
      quiet(8);
      expect_ev(1, 16'h0009, 8'h5a);
      apb(1'b1, 12'h00c, 32'h00000001);
      expect_ev(1, 16'h0009, 8'h5a);
      apb(1'b1, 12'h00c, 32'h00000000);
      apb(1'b1, 12'h014, 32'h00000005);
      apb(1'b1, 12'h000, 32'h00000ffd);
      occupied_in <= 1'b1;
      motion_in <= 1'b1;
      quiet(4);
      expect_ev(1, 16'h000a, 8'h01);
      occupied_in <= 1'b0;
      motion_in <= 1'b0;
      quiet(900);
      expect_ev(1, 16'h000b, 8'h00);
      apb(1'b1, 12'h010, 32'h00010001);
      expect_ev(1, 16'h000b, 8'h00);
      apb(1'b1, 12'h010, 32'h00000001);
      apb(1'b1, 12'h000, 32'h00001ffd);
      motion_in <= 1'b1;
      expect_ev(1, 16'h000c, 8'h00);
      rdchk(12'h020, 32'h0001045a, 1'b0);
      final_report;
   end
endmodule
`default_nettype wire
